// ---- rtl/ebpm_defines.svh ----
`ifndef EBPM_DEFINES_SVH
`define EBPM_DEFINES_SVH

// port 5 bit positions of the shared bus control pins
`define EBPM_BIT_WSL 2
`define EBPM_BIT_WSH 3
`define EBPM_BIT_HRQ 4
`define EBPM_BIT_HAK 5
`define EBPM_BIT_RDY 6
`define EBPM_BIT_CLK 7
`define EBPM_PORT_W 8
`define EBPM_BIT_PLAIN_HI 1
`define EBPM_BIT_PLAIN_LO 0
`define EBPM_CTRL_W 4

// bus pin control register field positions
`define EBPM_CTL_WRE 0
`define EBPM_CTL_HDE 1
`define EBPM_CTL_RYE 2
`define EBPM_CTL_CKE 3

// reset values
`define EBPM_CTRL_RST 4'h0
`define EBPM_PORT_RST 8'h00
`define EBPM_BIT_RST 1'h0
`define EBPM_BIT_ONE 1'h1

`endif

// ---- rtl/ebpm_pkg.sv ----
package ebpm_pkg;
    typedef logic [7:0] ebpm_port_t;
    typedef logic [3:0] ebpm_ctrl_t;
endpackage

// ---- rtl/ebpm_pin_mux.sv ----
// Operation
// - low write strobe on pin, else port
// - high write strobe in 16-bit mode, else port
// - hold request input on pin, else port
// - hold acknowledge output on pin, else port
// - ready input sampled on pin, else port
// - machine clock output on pin, else port
`timescale 1ns/1ns
`include "ebpm_defines.svh"

module ebpm_pin_mux (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ext_bus_mode,
    input wire logic bus_width_16,
    input wire ebpm_pkg::ebpm_ctrl_t bus_pin_control_reg,
    input wire ebpm_pkg::ebpm_port_t port_latch,
    input wire ebpm_pkg::ebpm_port_t port_dir,
    input wire logic write_strobe_low,
    input wire logic write_strobe_high,
    input wire logic hold_acknowledge_out,
    input wire logic mclk_level,
    input wire ebpm_pkg::ebpm_port_t pin_in,
    output ebpm_pkg::ebpm_port_t pin_out,
    output ebpm_pkg::ebpm_port_t pin_oe,
    output ebpm_pkg::ebpm_port_t port_read,
    output logic hold_request_in,
    output logic ready_in
);

    logic write_strobe_enable;
    logic hold_enable;
    logic ready_enable;
    logic clk_out_enable;
    // per-function selects, each gated by bus mode
    logic sel_wsl;
    logic sel_wsh;
    logic sel_hold;
    logic sel_rdy;
    logic sel_clk;
    // next pad drive, one bit per pin slot
    ebpm_pkg::ebpm_port_t out_d;
    ebpm_pkg::ebpm_port_t oe_d;

    // enables only count while the chip runs an external bus
    assign write_strobe_enable =
        bus_pin_control_reg[`EBPM_CTL_WRE];
    assign hold_enable = bus_pin_control_reg[`EBPM_CTL_HDE];
    assign ready_enable = bus_pin_control_reg[`EBPM_CTL_RYE];
    assign clk_out_enable = bus_pin_control_reg[`EBPM_CTL_CKE];
    assign sel_wsl = ext_bus_mode & write_strobe_enable;
    assign sel_wsh = sel_wsl & bus_width_16;
    assign sel_hold = ext_bus_mode & hold_enable;
    assign sel_rdy = ext_bus_mode & ready_enable;
    assign sel_clk = ext_bus_mode & clk_out_enable;

    // bits with no bus function stay plain port bits
    // i2c tristate is software's job through port_dir
    assign out_d[`EBPM_BIT_PLAIN_HI:`EBPM_BIT_PLAIN_LO] =
        port_latch[`EBPM_BIT_PLAIN_HI:`EBPM_BIT_PLAIN_LO];
    assign oe_d[`EBPM_BIT_PLAIN_HI:`EBPM_BIT_PLAIN_LO] =
        port_dir[`EBPM_BIT_PLAIN_HI:`EBPM_BIT_PLAIN_LO];

    // lower write strobe drives its pin while selected
    ebpm_pin_slot u_slot_wsl (
        .sel(sel_wsl),
        .fn_out(write_strobe_low),
        .fn_oe(`EBPM_BIT_ONE),
        .latch_bit(port_latch[`EBPM_BIT_WSL]),
        .dir_bit(port_dir[`EBPM_BIT_WSL]),
        .out_bit(out_d[`EBPM_BIT_WSL]),
        .oe_bit(oe_d[`EBPM_BIT_WSL])
    );

    // upper strobe only makes sense on a 16-bit bus
    // an 8-bit bus leaves this pin to the port
    ebpm_pin_slot u_slot_wsh (
        .sel(sel_wsh),
        .fn_out(write_strobe_high),
        .fn_oe(`EBPM_BIT_ONE),
        .latch_bit(port_latch[`EBPM_BIT_WSH]),
        .dir_bit(port_dir[`EBPM_BIT_WSH]),
        .out_bit(out_d[`EBPM_BIT_WSH]),
        .oe_bit(oe_d[`EBPM_BIT_WSH])
    );

    // request pin becomes a pure input
    // driving it would fight the requesting master
    ebpm_pin_slot u_slot_hrq (
        .sel(sel_hold),
        .fn_out(`EBPM_BIT_RST),
        .fn_oe(`EBPM_BIT_RST),
        .latch_bit(port_latch[`EBPM_BIT_HRQ]),
        .dir_bit(port_dir[`EBPM_BIT_HRQ]),
        .out_bit(out_d[`EBPM_BIT_HRQ]),
        .oe_bit(oe_d[`EBPM_BIT_HRQ])
    );

    // acknowledge shares the hold enable with the request
    ebpm_pin_slot u_slot_hak (
        .sel(sel_hold),
        .fn_out(hold_acknowledge_out),
        .fn_oe(`EBPM_BIT_ONE),
        .latch_bit(port_latch[`EBPM_BIT_HAK]),
        .dir_bit(port_dir[`EBPM_BIT_HAK]),
        .out_bit(out_d[`EBPM_BIT_HAK]),
        .oe_bit(oe_d[`EBPM_BIT_HAK])
    );

    // ready pin is an input while selected
    // slow devices pull it to stretch the access
    ebpm_pin_slot u_slot_rdy (
        .sel(sel_rdy),
        .fn_out(`EBPM_BIT_RST),
        .fn_oe(`EBPM_BIT_RST),
        .latch_bit(port_latch[`EBPM_BIT_RDY]),
        .dir_bit(port_dir[`EBPM_BIT_RDY]),
        .out_bit(out_d[`EBPM_BIT_RDY]),
        .oe_bit(oe_d[`EBPM_BIT_RDY])
    );

    // machine clock copy; registered, so it lags one cycle
    // and cannot toggle faster than half the core clock
    ebpm_pin_slot u_slot_clk (
        .sel(sel_clk),
        .fn_out(mclk_level),
        .fn_oe(`EBPM_BIT_ONE),
        .latch_bit(port_latch[`EBPM_BIT_CLK]),
        .dir_bit(port_dir[`EBPM_BIT_CLK]),
        .out_bit(out_d[`EBPM_BIT_CLK]),
        .oe_bit(oe_d[`EBPM_BIT_CLK])
    );

    // registered pad drive; costs one cycle of latency on every pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= `EBPM_PORT_RST;
            pin_oe <= `EBPM_PORT_RST;
        end else begin
            pin_out <= out_d;
            pin_oe <= oe_d;
        end
    end

    // port read path always sees the pin level
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_read <= `EBPM_PORT_RST;
        end else begin
            port_read <= pin_in;
        end
    end

    // hold request reads low while its pin is a port bit
    ebpm_fn_input #(
        .idle_level(`EBPM_BIT_RST)
    ) u_in_hold (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sel(sel_hold),
        .pad(pin_in[`EBPM_BIT_HRQ]),
        .value(hold_request_in)
    );

    // ready held high when unused so accesses never stall
    ebpm_fn_input #(
        .idle_level(`EBPM_BIT_ONE)
    ) u_in_rdy (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sel(sel_rdy),
        .pad(pin_in[`EBPM_BIT_RDY]),
        .value(ready_in)
    );

endmodule

// one shared pin: bus function or plain port bit
module ebpm_pin_slot (
    input wire logic sel,
    input wire logic fn_out,
    input wire logic fn_oe,
    input wire logic latch_bit,
    input wire logic dir_bit,
    output logic out_bit,
    output logic oe_bit
);

    // function overrides latch and direction while selected
    always_comb begin
        out_bit = latch_bit;
        oe_bit = dir_bit;
        if (sel) begin
            out_bit = fn_out;
            oe_bit = fn_oe;
        end
    end

endmodule

// registered function input with a safe idle level
module ebpm_fn_input #(
    parameter logic idle_level = `EBPM_BIT_RST
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sel,
    input wire logic pad,
    output logic value
);

    // unselected input parks at idle so bus logic never waits on a port pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= idle_level;
        end else if (sel) begin
            value <= pad;
        end else begin
            value <= idle_level;
        end
    end

endmodule

// ---- dv/ebpm_bus_partner.sv ----
`timescale 1ns/1ns
module ebpm_bus_partner (
    input wire logic [7:0] pin_out, pin_oe, noise,
    output logic [7:0] pad
);
    // undriven pads churn instead of holding a stale level
    assign pad = pin_oe & pin_out | ~pin_oe & noise;
endmodule

// ---- dv/ebpm_pin_mux_checker.sv ----
`timescale 1ns/1ns
module ebpm_pin_mux_checker (
    input wire logic core_clk, arst_n, ext_bus_mode, bus_width_16,
    input wire logic write_strobe_low, write_strobe_high, mclk_level,
    input wire logic hold_acknowledge_out, hold_request_in, ready_in,
    input wire logic [3:0] bus_pin_control_reg,
    input wire logic [7:0] port_latch, pin_in, pin_out, pin_oe
);
    // enables only count in bus mode; pads lag one edge
    wire logic [3:0] c = bus_pin_control_reg & {4{ext_bus_mode}};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    lo_strobe_a: assert property (c[0] |=> pin_oe[2] &&
        pin_out[2] == $past(write_strobe_low)) else $error("lo");
    hi_strobe_a: assert property (c[0] && bus_width_16 |=>
        pin_out[3] == $past(write_strobe_high)) else $error("hi");
    hold_req_a: assert property (c[1] |=>
        hold_request_in == $past(pin_in[4])) else $error("hrq");
    hold_ack_a: assert property (c[1] |=> pin_oe[5] &&
        pin_out[5] == $past(hold_acknowledge_out)) else $error("hak");
    ready_in_a: assert property (!c[2] |=> ready_in)
        else $error("rdy");
    clk_out_a: assert property (c[3] |=>
        pin_out[7] == $past(mclk_level)) else $error("clk");
    port_back_a: assert property (!c[0] |=>
        pin_out[2] == $past(port_latch[2])) else $error("port");
    hold_pin_in_a: assert property (c[1] |=> !pin_oe[4])
        else $error("hrq pin");
    ready_sel_a: assert property (c[2] |=> !pin_oe[6] &&
        ready_in == $past(pin_in[6])) else $error("rdy pin");
    hold_idle_a: assert property (!c[1] |=> !hold_request_in)
        else $error("hrq idle");
endmodule
bind ebpm_pin_mux ebpm_pin_mux_checker u_chk (.*);

// ---- dv/ebpm_pin_mux_tb.sv ----
`timescale 1ns/1ns
module ebpm_pin_mux_tb;
    logic core_clk = 0, arst_n = 0, hold_request_in, ready_in;
    logic ext_bus_mode, bus_width_16, write_strobe_low, write_strobe_high;
    logic hold_acknowledge_out, mclk_level;
    logic [3:0] bus_pin_control_reg;
    logic [7:0] port_latch, port_dir, pin_in, pin_out, pin_oe, port_read;
    logic [31:0] v = 32'h0, rs = 32'h7;
    logic [7:0] pad_seen;
    int errors, samples_checked, cyc;
    always @(posedge core_clk) pad_seen <= pin_in;
    // expected pad drive from the pin rules
    function automatic logic [15:0] exp_pins(logic [25:0] f);
        logic [7:0] o, e;
        logic [3:0] c;
        c = f[23:20] & {4{f[25]}};
        o = f[19:12];
        e = f[11:4];
        if (c[0]) begin
            o[2] = f[3];
            e[2] = 1'h1;
        end
        if (c[0] && f[24]) begin
            o[3] = f[2];
            e[3] = 1'h1;
        end
        if (c[1]) begin
            o[4] = 1'h0;
            e[4] = 1'h0;
            o[5] = f[1];
            e[5] = 1'h1;
        end
        if (c[2]) begin
            o[6] = 1'h0;
            e[6] = 1'h0;
        end
        if (c[3]) begin
            o[7] = f[0];
            e[7] = 1'h1;
        end
        return {o, e};
    endfunction
    assign {ext_bus_mode, bus_width_16, bus_pin_control_reg, port_latch,
        port_dir, write_strobe_low, write_strobe_high, hold_acknowledge_out,
        mclk_level} = v[25:0];
    ebpm_pin_mux u_dut (.*);
    ebpm_bus_partner u_far (.pin_out, .pin_oe, .noise(v[31:24]), .pad(pin_in));
    always #4 core_clk = ~core_clk;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ x << 5;
    endfunction
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard well past the 410 cycles needed
    always @(posedge core_clk) if (++cyc == 900) begin
        errors++;
        complete_run;
    end
    // random inputs; every fourth cycle turns every enable on
    initial begin
        repeat (10) @(posedge core_clk);
        #1 arst_n = 1;
        for (int i = 0; i < 400; i++) begin
            @(posedge core_clk);
            #1;
            if (i > 0) begin
                samples_checked += 2;
                if ({pin_out, pin_oe} !== exp_pins(v[25:0])) begin
                    errors++;
                    $display("[ERR] %0t port pins", $time);
                end
                if (port_read !== pad_seen) begin
                    errors++;
                    $display("[ERR] %0t port read", $time);
                end
            end
            rs = xs(rs);
            v = rs;
            if (i % 4 == 0) v[25:20] = 6'h3f;
            if (i % 4 == 2) v[25:20] = 6'h0f;
        end
        complete_run;
    end
endmodule
